// file: phy_ctrl_pkg.sv
/*
 * constants for the transceiver control and status register pair:
 * register numbers, field positions, reset values and encodings.
 * assumes a 5-bit management register number and 16-bit register data.
 */
package phy_ctrl_pkg;

	// ******************************************************************
	// register numbers on the management interface
	// ******************************************************************
	localparam logic [4:0] TRANSCEIVER_CONTROL_ADDR = 5'h10;
	localparam logic [4:0] TRANSCEIVER_STATUS_ADDR  = 5'h11;

	// ******************************************************************
	// control register fields
	// ******************************************************************
	localparam int CTL_XOVER_LSB   = 5;
	localparam int CTL_XOVER_MSB   = 6;
	localparam int CTL_CS_TX_BIT   = 3;
	localparam int CTL_SQE_BIT     = 2;
	localparam int CTL_POL_BIT     = 1;
	localparam int CTL_JAB_DIS_BIT = 0;

	localparam logic [1:0] XOVER_MDI   = 2'h0;
	localparam logic [1:0] XOVER_MDIX  = 2'h1;
	localparam logic [1:0] XOVER_RSVD  = 2'h2;
	localparam logic [1:0] XOVER_AUTO  = 2'h3;

	localparam logic [1:0] XOVER_MODE_RESET   = 2'h3;
	localparam logic       CS_ON_TX_RESET     = 1'h0;
	localparam logic       SQE_ENABLE_RESET   = 1'h0;
	localparam logic       POL_CORRECT_RESET  = 1'h1;
	localparam logic       JABBER_DIS_RESET   = 1'h0;

	// ******************************************************************
	// status register fields
	// ******************************************************************
	localparam int STS_SPEED_LSB    = 14;
	localparam int STS_SPEED_MSB    = 15;
	localparam int STS_DUPLEX_BIT   = 13;
	localparam int STS_PAGE_BIT     = 12;
	localparam int STS_RESOLVED_BIT = 11;
	localparam int STS_LINK_BIT     = 10;
	localparam int STS_XOVER_BIT    = 6;
	localparam int STS_DOWNGR_BIT   = 5;
	localparam int STS_TX_PAUSE_BIT = 3;
	localparam int STS_RX_PAUSE_BIT = 2;
	localparam int STS_POL_BIT      = 1;
	localparam int STS_JABBER_BIT   = 0;

	localparam logic [1:0] SPEED_10  = 2'h0;
	localparam logic [1:0] SPEED_100 = 2'h1;

	localparam logic [15:0] DATA_ZERO = 16'h0000;

endpackage

// file: crossover_resolver.sv
/*
 * holds the crossover mode that is in force and reports the wiring state.
 * assumes soft_reset_i is a one-cycle pulse in the clk_sys_i domain.
 */
`timescale 1ns/100ps
module crossover_resolver (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	input  wire logic       soft_reset_i,
	input  wire logic [1:0] crossover_mode_i,
	input  wire logic       auto_mdix_i,
	input  wire logic       resolved_i,
	output logic      [1:0] applied_mode_o,
	output logic            crossover_state_o
);

	logic next_state;

	// mode encoding
	// reserved code 10 falls back to straight wiring, the safe choice
	assign next_state = (applied_mode_o == phy_ctrl_pkg::XOVER_AUTO) ? auto_mdix_i :
	                    (applied_mode_o == phy_ctrl_pkg::XOVER_MDIX);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			applied_mode_o <= phy_ctrl_pkg::XOVER_MODE_RESET;
		end else if (soft_reset_i) begin
			applied_mode_o <= crossover_mode_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			crossover_state_o <= 1'b0;
		end else begin
			crossover_state_o <= resolved_i & next_state;
		end
	end

endmodule

// file: phy_control_status_registers.sv
/*
 * transceiver control and status register pair with the control outputs
 * they steer. assumes a management frame decoder outside that presents
 * one-cycle read and write strobes with a register number; all line
 * status inputs are synchronous to clk_sys_i.
 */
`timescale 1ns/100ps
module phy_control_status_registers (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	// register access from the management frame decoder
	input  wire logic [4:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	output logic             reg_rvalid_o,
	// device state
	input  wire logic        soft_reset_i,
	input  wire logic [1:0]  speed_i,
	input  wire logic        full_duplex_i,
	input  wire logic        link_up_i,
	input  wire logic        an_enable_i,
	input  wire logic        an_complete_i,
	input  wire logic        page_rx_i,
	input  wire logic        auto_mdix_i,
	input  wire logic        tx_pause_res_i,
	input  wire logic        rx_pause_res_i,
	input  wire logic        tx_active_i,
	input  wire logic        rx_active_i,
	input  wire logic        polarity_reversed_i,
	input  wire logic        jabber_i,
	input  wire logic        downgrade_i,
	// control outputs
	output logic             carrier_sense_o,
	output logic             sqe_test_enable_o,
	output logic             polarity_correction_o,
	output logic             jabber_detect_enable_o,
	output logic      [1:0]  crossover_applied_o
);

	// ******************************************************************
	// helpers
	// ******************************************************************
	function automatic logic is_ten_meg(input logic [1:0] speed);
		is_ten_meg = (speed == phy_ctrl_pkg::SPEED_10);
	endfunction

	function automatic logic is_hundred_meg(input logic [1:0] speed);
		is_hundred_meg = (speed == phy_ctrl_pkg::SPEED_100);
	endfunction

	// ******************************************************************
	// control register
	// ******************************************************************
	logic [1:0] crossover_mode;
	logic       carrier_sense_on_transmit;
	logic       signal_quality_test_enable;
	logic       polarity_correction_enable;
	logic       jabber_detect_disable;

	wire sel_control = (reg_addr_i == phy_ctrl_pkg::TRANSCEIVER_CONTROL_ADDR);
	wire sel_status  = (reg_addr_i == phy_ctrl_pkg::TRANSCEIVER_STATUS_ADDR);
	wire wr_control  = reg_wr_i & sel_control;
	wire rd_status   = reg_rd_i & sel_status;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			crossover_mode             <= phy_ctrl_pkg::XOVER_MODE_RESET;
			carrier_sense_on_transmit  <= phy_ctrl_pkg::CS_ON_TX_RESET;
			signal_quality_test_enable <= phy_ctrl_pkg::SQE_ENABLE_RESET;
			polarity_correction_enable <= phy_ctrl_pkg::POL_CORRECT_RESET;
			jabber_detect_disable      <= phy_ctrl_pkg::JABBER_DIS_RESET;
		end else if (wr_control) begin
			crossover_mode <=
				reg_wdata_i[phy_ctrl_pkg::CTL_XOVER_MSB:phy_ctrl_pkg::CTL_XOVER_LSB];
			carrier_sense_on_transmit  <= reg_wdata_i[phy_ctrl_pkg::CTL_CS_TX_BIT];
			signal_quality_test_enable <= reg_wdata_i[phy_ctrl_pkg::CTL_SQE_BIT];
			polarity_correction_enable <= reg_wdata_i[phy_ctrl_pkg::CTL_POL_BIT];
			jabber_detect_disable      <= reg_wdata_i[phy_ctrl_pkg::CTL_JAB_DIS_BIT];
		end
	end

	// ******************************************************************
	// resolution and crossover
	// ******************************************************************
	logic crossover_state;

	wire resolved = ~an_enable_i | an_complete_i;

	crossover_resolver u_xover (
		.clk_sys_i         (clk_sys_i),
		.rst_n_i           (rst_n_i),
		.soft_reset_i      (soft_reset_i),
		.crossover_mode_i  (crossover_mode),
		.auto_mdix_i       (auto_mdix_i),
		.resolved_i        (resolved),
		.applied_mode_o    (crossover_applied_o),
		.crossover_state_o (crossover_state)
	);

	// ******************************************************************
	// datapath steering
	// ******************************************************************
	wire ten_meg     = is_ten_meg(speed_i);
	wire hundred_meg = is_hundred_meg(speed_i);

	wire cs_tx_applies = hundred_meg | (ten_meg & ~full_duplex_i);

	wire next_carrier_sense = rx_active_i |
	                          (tx_active_i & carrier_sense_on_transmit & cs_tx_applies);

	wire next_sqe = signal_quality_test_enable & ~full_duplex_i;

	wire jabber_seen = jabber_i & ten_meg & ~jabber_detect_disable;

	wire polarity_seen = polarity_reversed_i &
	                     ~(ten_meg & ~polarity_correction_enable);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			carrier_sense_o        <= 1'b0;
			sqe_test_enable_o      <= phy_ctrl_pkg::SQE_ENABLE_RESET;
			polarity_correction_o  <= phy_ctrl_pkg::POL_CORRECT_RESET;
			jabber_detect_enable_o <= ~phy_ctrl_pkg::JABBER_DIS_RESET;
		end else begin
			carrier_sense_o        <= next_carrier_sense;
			sqe_test_enable_o      <= next_sqe;
			polarity_correction_o  <= polarity_correction_enable;
			jabber_detect_enable_o <= ~jabber_detect_disable;
		end
	end

	// ******************************************************************
	// page received flag
	// ******************************************************************
	logic page_received;

	// sticky, clear on read
	// an arriving page in the read cycle wins so it is never lost
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			page_received <= 1'b0;
		end else if (page_rx_i) begin
			page_received <= 1'b1;
		end else if (rd_status) begin
			page_received <= 1'b0;
		end
	end

	// ******************************************************************
	// read data
	// ******************************************************************
	// pause valid only after negotiation
	wire pause_valid = an_enable_i & an_complete_i;

	logic [15:0] control_word;
	logic [15:0] status_word;
	logic [15:0] next_rdata;

	always_comb begin
		control_word = phy_ctrl_pkg::DATA_ZERO;
		control_word[phy_ctrl_pkg::CTL_XOVER_MSB:phy_ctrl_pkg::CTL_XOVER_LSB] = crossover_mode;
		control_word[phy_ctrl_pkg::CTL_CS_TX_BIT]   = carrier_sense_on_transmit;
		control_word[phy_ctrl_pkg::CTL_SQE_BIT]     = signal_quality_test_enable;
		control_word[phy_ctrl_pkg::CTL_POL_BIT]     = polarity_correction_enable;
		control_word[phy_ctrl_pkg::CTL_JAB_DIS_BIT] = jabber_detect_disable;
	end

	always_comb begin
		status_word = phy_ctrl_pkg::DATA_ZERO;
		status_word[phy_ctrl_pkg::STS_SPEED_MSB:phy_ctrl_pkg::STS_SPEED_LSB] = speed_i;
		status_word[phy_ctrl_pkg::STS_DUPLEX_BIT]   = full_duplex_i;
		status_word[phy_ctrl_pkg::STS_PAGE_BIT]     = page_received;
		status_word[phy_ctrl_pkg::STS_RESOLVED_BIT] = resolved;
		status_word[phy_ctrl_pkg::STS_LINK_BIT]     = link_up_i;
		status_word[phy_ctrl_pkg::STS_XOVER_BIT]    = crossover_state;
		status_word[phy_ctrl_pkg::STS_DOWNGR_BIT]   = downgrade_i;
		status_word[phy_ctrl_pkg::STS_TX_PAUSE_BIT] = tx_pause_res_i & pause_valid;
		status_word[phy_ctrl_pkg::STS_RX_PAUSE_BIT] = rx_pause_res_i & pause_valid;
		status_word[phy_ctrl_pkg::STS_POL_BIT]      = polarity_seen;
		status_word[phy_ctrl_pkg::STS_JABBER_BIT]   = jabber_seen;
	end

	// unmapped register numbers read as zero
	assign next_rdata = sel_control ? control_word :
	                    sel_status  ? status_word  : phy_ctrl_pkg::DATA_ZERO;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			reg_rdata_o  <= phy_ctrl_pkg::DATA_ZERO;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata;
			end
		end
	end

endmodule

// file: phy_ctrl_assertions.sv
/*
 * checker for the transceiver control and status register pair.
 * assumes it is bound to the register block top and sees its ports only.
 */
`timescale 1ns/100ps
module phy_ctrl_checker (
	input wire logic        clk_sys_i,
	input wire logic        rst_n_i,
	input wire logic [4:0]  reg_addr_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic        reg_rvalid_o,
	input wire logic        soft_reset_i,
	input wire logic        full_duplex_i,
	input wire logic        page_rx_i,
	input wire logic        tx_active_i,
	input wire logic        rx_active_i,
	input wire logic        carrier_sense_o,
	input wire logic        sqe_test_enable_o,
	input wire logic        polarity_correction_o,
	input wire logic        jabber_detect_enable_o,
	input wire logic [1:0]  crossover_applied_o
);
	wire        ctl_hit = reg_addr_i == phy_ctrl_pkg::TRANSCEIVER_CONTROL_ADDR;
	wire        sts_hit = reg_addr_i == phy_ctrl_pkg::TRANSCEIVER_STATUS_ADDR;
	wire        ctl_wr  = reg_wr_i && ctl_hit;
	wire        sts_rd  = reg_rd_i && sts_hit;
	logic [1:0] mode_q;
	logic       flag_q;

	// ********************************
	// reference state and properties
	// ********************************
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			mode_q <= phy_ctrl_pkg::XOVER_MODE_RESET;
			flag_q <= 1'b0;
		end else begin
			mode_q <= ctl_wr ? reg_wdata_i[6:5] : mode_q;
			flag_q <= page_rx_i | (flag_q & !sts_rd);
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_quiet_line;
		!tx_active_i && !rx_active_i;
	endsequence
	property p_read_answer; reg_rd_i |=> reg_rvalid_o; endproperty
	property p_ctl_rsvd; reg_rd_i && ctl_hit |=> (reg_rdata_o & 16'hFF90) == 16'h0000; endproperty
	property p_unmapped; reg_rd_i && !ctl_hit && !sts_hit |=> reg_rdata_o == 16'h0000; endproperty
	property p_sqe_fd; full_duplex_i |=> !sqe_test_enable_o; endproperty
	// outputs follow the control bits one clock after the register takes the write
	property p_jab; ctl_wr |-> ##2 jabber_detect_enable_o == !$past(reg_wdata_i[0], 2); endproperty
	property p_pol; ctl_wr |-> ##2 polarity_correction_o == $past(reg_wdata_i[1], 2); endproperty
	property p_cs_rx; rx_active_i |=> carrier_sense_o; endproperty
	property p_cs_idle; s_quiet_line |=> !carrier_sense_o; endproperty
	property p_hold; !soft_reset_i |=> $stable(crossover_applied_o); endproperty
	property p_apply; soft_reset_i && !ctl_wr |=> crossover_applied_o == $past(mode_q); endproperty
	property p_page; sts_rd |=> reg_rdata_o[12] == $past(flag_q); endproperty
	a_read_answer: assert property (p_read_answer) else $error("read without answer");
	a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("reserved control bits set");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_sqe_fd: assert property (p_sqe_fd) else $error("quality test on in full duplex");
	a_jab: assert property (p_jab) else $error("jabber enable wrong");
	a_pol: assert property (p_pol) else $error("polarity correction wrong");
	a_cs_rx: assert property (p_cs_rx) else $error("no carrier sense on receive");
	a_cs_idle: assert property (p_cs_idle) else $error("carrier sense while idle");
	a_hold: assert property (p_hold) else $error("mode changed without soft reset");
	a_apply: assert property (p_apply) else $error("soft reset did not apply mode");
	a_page: assert property (p_page) else $error("page flag read wrong");
endmodule

bind phy_control_status_registers phy_ctrl_checker chk_u (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .soft_reset_i(soft_reset_i),
	.full_duplex_i(full_duplex_i), .page_rx_i(page_rx_i), .tx_active_i(tx_active_i),
	.rx_active_i(rx_active_i), .carrier_sense_o(carrier_sense_o),
	.sqe_test_enable_o(sqe_test_enable_o), .polarity_correction_o(polarity_correction_o),
	.jabber_detect_enable_o(jabber_detect_enable_o),
	.crossover_applied_o(crossover_applied_o));

// file: line_partner.sv
/*
 * line-side partner: negotiation progress and one page arrival.
 * assumes start_i changes off the rising edge.
 */
`timescale 1ns/100ps
module line_partner (
	input  wire logic clk_sys_i,
	input  wire logic start_i,
	output logic      an_complete_o,
	output logic      page_rx_o
);
	logic [2:0] step = 3'h0;
	always @(posedge clk_sys_i)
		step <= !start_i ? 3'h0 : step + {2'h0, step != 3'h7};
	assign page_rx_o     = step == 3'h2;
	assign an_complete_o = step > 3'h4;
endmodule

// file: tb_top.sv
/*
 * bench for the register pair: register strobes, line state, partner.
 * assumes the strobe port contract of the register block.
 */
`timescale 1ns/100ps
module tb_top;
	localparam logic [4:0] CTL = phy_ctrl_pkg::TRANSCEIVER_CONTROL_ADDR;
	localparam logic [4:0] STS = phy_ctrl_pkg::TRANSCEIVER_STATUS_ADDR;
	logic        clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, soft_reset_i, start;
	logic [4:0]  reg_addr_i;
	logic [15:0] reg_wdata_i, reg_rdata_o;
	logic [1:0]  speed_i, crossover_applied_o, prev;
	logic        full_duplex_i, an_enable_i, an_complete_i, page_rx_i, pause_i;
	logic        tx_active_i, rx_active_i, auto_mdix_i, reg_rvalid_o, cs_o;
	logic        sqe_o, pol_o, jab_en_o, rev_i, jab_i;
	int          err_count, tests_run;

	phy_control_status_registers dut_u (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .soft_reset_i(soft_reset_i),
		.speed_i(speed_i), .full_duplex_i(full_duplex_i), .link_up_i(1'b1),
		.an_enable_i(an_enable_i), .an_complete_i(an_complete_i), .page_rx_i(page_rx_i),
		.auto_mdix_i(auto_mdix_i), .tx_pause_res_i(pause_i), .rx_pause_res_i(pause_i),
		.tx_active_i(tx_active_i), .rx_active_i(rx_active_i), .polarity_reversed_i(rev_i),
		.jabber_i(jab_i), .downgrade_i(1'b0), .carrier_sense_o(cs_o),
		.sqe_test_enable_o(sqe_o), .polarity_correction_o(pol_o),
		.jabber_detect_enable_o(jab_en_o), .crossover_applied_o(crossover_applied_o));
	line_partner far_u (.clk_sys_i(clk_sys_i), .start_i(start),
		.an_complete_o(an_complete_i), .page_rx_o(page_rx_i));

	// ********************************
	// access tasks
	// ********************************
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// a spare cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_addr_i  = a;
		reg_wdata_i = d;
		reg_wr_i    = 1'b1;
		tick(1);
		reg_wr_i    = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
		reg_addr_i = a;
		reg_rd_i   = 1'b1;
		tick(1);
		reg_rd_i   = 1'b0;
		chk(reg_rvalid_o === 1'b1 ? reg_rdata_o & m : 16'hxxxx, e);
		tick(1);
	endtask
	task automatic finish_test();
		$display("checks %0d, errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ********************************
	// clock, watchdog and tests
	// ********************************
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		repeat (2000) @(posedge clk_sys_i);
		err_count++;
		finish_test();
	end
	initial begin
		{rst_n_i, reg_wr_i, reg_rd_i, soft_reset_i, start} = 5'h00;
		{full_duplex_i, an_enable_i, pause_i, tx_active_i, rx_active_i, auto_mdix_i} = 6'h09;
		{reg_addr_i, reg_wdata_i, speed_i, prev} = 25'h000_0007;
		{rev_i, jab_i} = 2'h0;
		err_count = 0;
		tests_run = 0;
		tick(3);
		rst_n_i = 1'b1;
		chk({10'h000, cs_o, crossover_applied_o, sqe_o, pol_o, jab_en_o}, 16'h001B);
		rd(CTL, 16'hFFFF, 16'h0062);
		wr(CTL, 16'hFFFF);
		rd(CTL, 16'hFFFF, 16'h006F);
		chk({14'h0000, pol_o, jab_en_o}, 16'h0002);
		wr(CTL, 16'h0060);
		chk({14'h0000, pol_o, jab_en_o}, 16'h0001);
		wr(STS, 16'hFFFF);
		wr(5'h07, 16'hFFFF);
		rd(CTL, 16'hFFFF, 16'h0060);
		rd(5'h07, 16'hFFFF, 16'h0000);
		for (int m = 0; m < 4; m++) begin
			wr(CTL, {9'h000, m[1:0], 5'h02});
			chk({14'h0000, crossover_applied_o}, {14'h0000, prev});
			rd(STS, 16'h0040, prev[0] ? 16'h0040 : 16'h0000);
			soft_reset_i = 1'b1;
			tick(1);
			soft_reset_i = 1'b0;
			tick(2);
			chk({14'h0000, crossover_applied_o}, {14'h0000, m[1:0]});
			rd(STS, 16'h0040, m[0] ? 16'h0040 : 16'h0000);
			prev = m[1:0];
		end
		wr(CTL, 16'h006A);
		tx_active_i = 1'b1;
		tick(2);
		chk({15'h0000, cs_o}, 16'h0001);
		wr(CTL, 16'h0062);
		chk({15'h0000, cs_o}, 16'h0000);
		wr(CTL, 16'h006A);
		{speed_i, full_duplex_i} = 3'h1;
		tick(2);
		chk({15'h0000, cs_o}, 16'h0000);
		rx_active_i = 1'b1;
		tick(2);
		chk({15'h0000, cs_o}, 16'h0001);
		{tx_active_i, rx_active_i} = 2'h0;
		wr(CTL, 16'h0066);
		chk({15'h0000, sqe_o}, 16'h0000);
		full_duplex_i = 1'b0;
		tick(2);
		chk({15'h0000, sqe_o}, 16'h0001);
		an_enable_i = 1'b1;
		start = 1'b1;
		tick(1);
		rd(STS, 16'h084C, 16'h0000);
		for (int i = 0; i < 20 && an_complete_i !== 1'b1; i++)
			tick(1);
		tick(2);
		rd(STS, 16'h180C, 16'h180C);
		rd(STS, 16'h180C, 16'h080C);
		an_enable_i = 1'b0;
		tick(2);
		rd(STS, 16'h080C, 16'h0800);
		{rev_i, jab_i} = 2'h3;
		rd(STS, 16'h0003, 16'h0003);
		wr(CTL, 16'h0060);
		rd(STS, 16'h0003, 16'h0001);
		wr(CTL, 16'h0063);
		rd(STS, 16'h0003, 16'h0002);
		finish_test();
	end
endmodule
